// File: src/tx_link_debug_status.sv
// Purpose: link debug status bank on Avalon-MM with interrupt, read-only except the interrupt mask and status
// Assumes: Avalon-MM slave with waitrequest, all inputs synchronous to clk_i
// Notes: one wait state per access
// What this block does
// - ILAS multiframe counter, minus-one binary, in bits 10:3.
// - data link layer state in bit 2, read-only, resets zero.
// - internal SYNC_N value in bits 1:0.
// - offset 0x84: lane FIFO empty flags bits 23:16; 31:24 read zero.
// - same register: lane FIFO full flags bits 7:0; 15:8 read zero.
`timescale 1ns/1ps
`include "tx_link_debug_regs.svh"
module tx_link_debug_status (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	output logic      [1:0]  avs_response_o,
	input  wire logic [7:0]  ilas_count_i,
	input  wire logic        dll_state_i,
	input  wire logic [1:0]  sync_value_i,
	input  wire logic [7:0]  lane_phase_fifo_empty_flag_i,
	input  wire logic [7:0]  lane_phase_fifo_full_flag_i,
	output logic             irq_o
);
	tx_link_debug_snap_if snap ();

	tx_link_debug_capture u_capture (
		.clk_i                        (clk_i),
		.rst_n_i                      (rst_n_i),
		.ilas_count_i                 (ilas_count_i),
		.dll_state_i                  (dll_state_i),
		.sync_value_i                 (sync_value_i),
		.lane_phase_fifo_empty_flag_i (lane_phase_fifo_empty_flag_i),
		.lane_phase_fifo_full_flag_i  (lane_phase_fifo_full_flag_i),
		.snap                         (snap)
	);

	tx_link_debug_pkg::bus_state_type state;
	tx_link_debug_pkg::bus_state_type next_state;
	logic [31:0]       rdata;
	logic [31:0]       next_rdata;
	logic [1:0]        resp;
	logic [1:0]        next_resp;
	logic [`IRQ_W-1:0] irq_status;
	logic [`IRQ_W-1:0] next_irq_status;
	logic [`IRQ_W-1:0] irq_mask;
	logic [`IRQ_W-1:0] next_irq_mask;
	logic              dll_prev;
	logic [1:0]        sync_prev;
	logic [`IRQ_W-1:0] events;
	logic [31:0]       link_word;
	logic [31:0]       fifo_word;
	logic              next_dll_prev;
	logic [1:0]        next_sync_prev;
	logic              take_read;
	logic              take_write;
	logic [31:0]       read_word;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `OFF_LINK_STATE) || (a == `OFF_LANE_FIFO) ||
			(a == `OFF_IRQ_STATUS) || (a == `OFF_IRQ_MASK);
	endfunction : mapped

	always_comb
	begin
		link_word = `RESET_WORD;
		link_word[`ILAS_MSB:`ILAS_LSB] = snap.ilas_count;
		link_word[`DLL_BIT]            = snap.dll_state;
		link_word[`SYNC_MSB:`SYNC_LSB] = snap.sync_value;
	end

	// reserved bits stay zero from the reset word
	always_comb
	begin
		fifo_word = `RESET_WORD;
		for (int i = 0; i < `LANES; i++)
		begin
			fifo_word[`EMPTY_LSB + i] = snap.fifo_empty[i];
			fifo_word[`FULL_LSB + i]  = snap.fifo_full[i];
		end
	end

	// events: sync request seen, any lane full, link state change
	always_comb
	begin
		events = '0;
		events[`IRQ_SYNC_REQ]   = (sync_prev != 2'h0) && (snap.sync_value == 2'h0);
		events[`IRQ_FULL]       = |snap.fifo_full;
		events[`IRQ_DLL_CHANGE] = dll_prev != snap.dll_state;
	end

	// requests are taken only from idle; read wins if both are raised
	always_comb
	begin
		take_read  = (state == tx_link_debug_pkg::BUS_IDLE) && avs_read_i;
		take_write = (state == tx_link_debug_pkg::BUS_IDLE) && avs_write_i && !avs_read_i;
	end

	always_comb
	begin
		unique case (avs_address_i)
			`OFF_LINK_STATE: read_word = link_word;
			`OFF_LANE_FIFO:  read_word = fifo_word;
			`OFF_IRQ_STATUS: read_word = {29'h0, irq_status};
			`OFF_IRQ_MASK:   read_word = {29'h0, irq_mask};
			default:         read_word = `RESET_WORD;
		endcase
	end

	// bus handshake group
	always_comb
	begin
		next_state = state;
		next_rdata = rdata;
		next_resp  = resp;
		unique case (state)
			tx_link_debug_pkg::BUS_IDLE:
			begin
				if (take_read)
				begin
					next_state = tx_link_debug_pkg::BUS_READ;
					next_rdata = read_word;
					next_resp  = mapped(avs_address_i) ? 2'h0 : 2'h3;
				end
				else if (take_write)
				begin
					next_state = tx_link_debug_pkg::BUS_WRITE;
					next_resp  = mapped(avs_address_i) ? 2'h0 : 2'h3;
				end
			end
			tx_link_debug_pkg::BUS_READ:
			begin
				next_state = tx_link_debug_pkg::BUS_IDLE;
			end
			tx_link_debug_pkg::BUS_WRITE:
			begin
				next_state = tx_link_debug_pkg::BUS_IDLE;
			end
			default:
				next_state = tx_link_debug_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state <= tx_link_debug_pkg::BUS_IDLE;
			rdata <= `RESET_WORD;
			resp  <= 2'h0;
		end
		else
		begin
			state <= next_state;
			rdata <= next_rdata;
			resp  <= next_resp;
		end
	end

	// interrupt group: an event in the clearing cycle wins over the clear
	always_comb
	begin
		next_irq_mask   = irq_mask;
		next_irq_status = irq_status;
		if (take_write && avs_byteenable_i[0])
		begin
			if (avs_address_i == `OFF_IRQ_MASK)
				next_irq_mask = avs_writedata_i[`IRQ_W-1:0];
			if (avs_address_i == `OFF_IRQ_STATUS)
				next_irq_status = irq_status & ~avs_writedata_i[`IRQ_W-1:0];
		end
		next_irq_status = next_irq_status | events;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			irq_status <= '0;
			irq_mask   <= '0;
		end
		else
		begin
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
		end
	end

	// history of link state for the edge events
	always_comb
	begin
		next_dll_prev  = snap.dll_state;
		next_sync_prev = snap.sync_value;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			dll_prev  <= 1'b0;
			sync_prev <= 2'h0;
		end
		else
		begin
			dll_prev  <= next_dll_prev;
			sync_prev <= next_sync_prev;
		end
	end

	assign avs_waitrequest_o = (state == tx_link_debug_pkg::BUS_IDLE);
	assign avs_readdata_o    = rdata;
	assign avs_response_o    = resp;
	assign irq_o             = |(irq_status & irq_mask);
endmodule : tx_link_debug_status

// File: src/tx_link_debug_regs.svh
// Purpose: offsets, field positions and reset values of the link debug status bank
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef TX_LINK_DEBUG_REGS_SVH
`define TX_LINK_DEBUG_REGS_SVH

`define ADDR_W              8
`define OFF_LINK_STATE      8'h80
`define OFF_LANE_FIFO       8'h84
`define OFF_IRQ_STATUS      8'h88
`define OFF_IRQ_MASK        8'h8C
`define SYNC_LSB            0
`define SYNC_MSB            1
`define DLL_BIT             2
`define ILAS_LSB            3
`define ILAS_MSB            10
`define FULL_LSB            0
`define EMPTY_LSB           16
`define LANES               8
`define RESET_WORD          32'h0000_0000
`define IRQ_W               3
`define IRQ_SYNC_REQ        0
`define IRQ_FULL            1
`define IRQ_DLL_CHANGE      2

`endif

// File: src/tx_link_debug_pkg.sv
// Purpose: types shared by the debug status bank
// Assumes: nothing
// Notes: constants live in tx_link_debug_regs.svh
package tx_link_debug_pkg;
	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b001,
		BUS_READ  = 3'b010,
		BUS_WRITE = 3'b100
	} bus_state_type;
endpackage : tx_link_debug_pkg

// File: src/tx_link_debug_snap_if.sv
// Purpose: link status (registered state fields, live FIFO flags) carried from capture stage to register file
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
interface tx_link_debug_snap_if;
	logic [7:0] ilas_count;
	logic       dll_state;
	logic [1:0] sync_value;
	logic [7:0] fifo_empty;
	logic [7:0] fifo_full;
	modport source (output ilas_count, dll_state, sync_value, fifo_empty, fifo_full);
	modport sink   (input  ilas_count, dll_state, sync_value, fifo_empty, fifo_full);
endinterface : tx_link_debug_snap_if

// File: src/tx_link_debug_capture.sv
// Purpose: registers link-state status and passes lane FIFO flags through live
// Assumes: all inputs synchronous to clk_i
// Notes: state fields register once, FIFO flags are not latched
`timescale 1ns/1ps
`include "tx_link_debug_regs.svh"
module tx_link_debug_capture (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  ilas_count_i,
	input  wire logic        dll_state_i,
	input  wire logic [1:0]  sync_value_i,
	input  wire logic [7:0]  lane_phase_fifo_empty_flag_i,
	input  wire logic [7:0]  lane_phase_fifo_full_flag_i,
	tx_link_debug_snap_if.source snap
);
	logic [7:0] ilas_q;
	logic       dll_q;
	logic [1:0] sync_q;
	logic [7:0] next_ilas_q;
	logic       next_dll_q;
	logic [1:0] next_sync_q;

	always_comb
	begin
		next_ilas_q = ilas_count_i;
		next_dll_q  = dll_state_i;
		next_sync_q = sync_value_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ilas_q <= 8'h00;
			dll_q  <= 1'b0;
			sync_q <= 2'h0;
		end
		else
		begin
			ilas_q <= next_ilas_q;
			dll_q  <= next_dll_q;
			sync_q <= next_sync_q;
		end
	end

	always_comb
	begin
		snap.ilas_count = ilas_q;
		snap.dll_state  = dll_q;
		snap.sync_value = sync_q;
		// live flags, forced clear in reset
		snap.fifo_empty = rst_n_i ? lane_phase_fifo_empty_flag_i : 8'h00;
		snap.fifo_full  = rst_n_i ? lane_phase_fifo_full_flag_i : 8'h00;
	end
endmodule : tx_link_debug_capture

// File: verification/tx_link_debug_status_monitor.sv
// Purpose: port checks of the debug status bank
// Assumes: one clock
// Notes: bound to the top module
`timescale 1ns/1ps
module tx_link_debug_status_monitor (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic [7:0]  ilas_count_i,
	input wire logic        dll_state_i,
	input wire logic [1:0]  sync_value_i,
	input wire logic [7:0]  lane_phase_fifo_empty_flag_i,
	input wire logic [7:0]  lane_phase_fifo_full_flag_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire rd = avs_read_i && !avs_waitrequest_o;
	wire rd80 = rd && avs_address_i == 8'h80;
	wire rd84 = rd && avs_address_i == 8'h84;
	AST_ILAS: assert property (rd80 |-> avs_readdata_o[10:3] == $past(ilas_count_i, 2))
		else $error("ilas count mismatch");
	AST_DLL: assert property (rd80 |-> avs_readdata_o[2] == $past(dll_state_i, 2))
		else $error("link state mismatch");
	AST_SYNC: assert property (rd80 |-> avs_readdata_o[1:0] == $past(sync_value_i, 2))
		else $error("sync value mismatch");
	AST_EMPTY: assert property (rd84 |-> avs_readdata_o[23:16] == $past(lane_phase_fifo_empty_flag_i))
		else $error("empty flags mismatch");
	AST_FULL: assert property (rd84 |-> avs_readdata_o[7:0] == $past(lane_phase_fifo_full_flag_i))
		else $error("full flags mismatch");
	AST_RSV: assert property (rd84 |-> avs_readdata_o[31:24] == 8'h00 && avs_readdata_o[15:8] == 8'h00)
		else $error("reserved bits set");
endmodule : tx_link_debug_status_monitor
bind tx_link_debug_status tx_link_debug_status_monitor tx_link_debug_status_monitor_i (.*);

// File: verification/tx_link_partner.sv
// Purpose: link layer and lane FIFO status source
// Assumes: values held stable between loads
// Notes: word is ilas, dll, sync, empty, full
`timescale 1ns/1ps
module tx_link_partner (
	input  wire logic [26:0] word_i,
	output logic      [7:0]  ilas_o,
	output logic             dll_o,
	output logic      [1:0]  sync_o,
	output logic      [7:0]  empty_o,
	output logic      [7:0]  full_o
);
	assign {ilas_o, dll_o, sync_o, empty_o, full_o} = word_i;
endmodule : tx_link_partner

// File: verification/test_tx_link_debug_status.sv
// Purpose: register level test of the debug status bank
// Assumes: mask bit one enables its interrupt
// Notes: link values come from the partner
`timescale 1ns/1ps
module test_tx_link_debug_status;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [7:0]  ad = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] rdat;
	logic [1:0]  rsp;
	logic [26:0] w = 27'h0;
	logic [26:0] tv [0:2];
	wire logic [7:0]  ilas, empty, full;
	wire logic        dll, irq, wq;
	wire logic [1:0]  sync, resp;
	wire logic [31:0] rdt;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	always #50 clk_i = ~clk_i;
	tx_link_partner tx_link_partner_i (.word_i(w), .ilas_o(ilas), .dll_o(dll),
		.sync_o(sync), .empty_o(empty), .full_o(full));
	tx_link_debug_status tx_link_debug_status_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdt), .avs_waitrequest_o(wq),
		.avs_response_o(resp), .ilas_count_i(ilas), .dll_state_i(dll),
		.sync_value_i(sync), .lane_phase_fifo_empty_flag_i(empty),
		.lane_phase_fifo_full_flag_i(full), .irq_o(irq));
	task summarize;
		$display("mismatches %0d, checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task acc(input logic is_w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		rd <= !is_w;
		wr <= is_w;
		ad <= a;
		wd <= d;
		do @(posedge clk_i); while (wq !== 1'b0);
		rdat = rdt;
		rsp = resp;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : acc
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", n, e, s);
			n_mismatch++;
		end
	endtask : chk
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	initial
	begin
		tv = '{{8'hFF, 1'h1, 2'h3, 8'h80, 8'h01}, {8'h01, 1'h0, 2'h1, 8'h01, 8'h80},
			{8'h5A, 1'h1, 2'h2, 8'hA5, 8'h00}};
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		acc(1'b0, 8'h80, 32'h0);
		chk("link reset", 32'h0, rdat);
		chk("link resp", 32'h0, {30'h0, rsp});
		acc(1'b0, 8'h84, 32'h0);
		chk("fifo reset", 32'h0, rdat);
		acc(1'b0, 8'h90, 32'h0);
		chk("unmapped data", 32'h0, rdat);
		chk("unmapped resp", 32'h3, {30'h0, rsp});
		for (int i = 0; i < 3; i++)
		begin
			w <= tv[i];
			repeat (3) @(posedge clk_i);
			acc(1'b0, 8'h80, 32'h0);
			chk("link word", {21'h0, tv[i][26:16]}, rdat);
			acc(1'b1, 8'h84, 32'hFFFF_FFFF);
			acc(1'b0, 8'h84, 32'h0);
			chk("fifo word", {8'h0, tv[i][15:8], 8'h0, tv[i][7:0]}, rdat);
		end
		acc(1'b0, 8'h88, 32'h0);
		chk("irq status", 32'h6, rdat);
		chk("irq masked", 32'h0, {31'h0, irq});
		acc(1'b1, 8'h8C, 32'h2);
		@(posedge clk_i);
		chk("irq raised", 32'h1, {31'h0, irq});
		acc(1'b1, 8'h88, 32'h6);
		@(posedge clk_i);
		chk("irq cleared", 32'h0, {31'h0, irq});
		w <= 27'h0;
		repeat (3) @(posedge clk_i);
		acc(1'b0, 8'h88, 32'h0);
		chk("irq sync dll", 32'h5, rdat);
		chk("irq still masked", 32'h0, {31'h0, irq});
		acc(1'b1, 8'h8C, 32'h5);
		@(posedge clk_i);
		chk("irq sync dll", 32'h1, {31'h0, irq});
		rst_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		chk("irq after reset", 32'h0, {31'h0, irq});
		acc(1'b0, 8'h8C, 32'h0);
		chk("mask after reset", 32'h0, rdat);
		acc(1'b0, 8'h88, 32'h0);
		chk("status after reset", 32'h0, rdat);
		acc(1'b0, 8'h80, 32'h0);
		chk("link after reset", 32'h0, rdat);
		summarize();
	end
endmodule : test_tx_link_debug_status
